// *** sim/test_adcseq_top.sv ***
// testbench: registers, pins and conversion timing of the conversion sequencer
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module test_adcseq_top
  import adcseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, psel, penable, pwrite, rc_clk, cmp_high, small_pkg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, sample_closed, vref_pos_ext, vref_neg_ext, irq, rerr;
  logic [15:0] pad_in, pad_digital_en, pad_dig_in, ex;
  logic [9:0] dac_code, v;
  int failures = 0;
  int check_count = 0;
  int acq, low, nn;
  // zero marks the rc clock selections
  int divs [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  int acqp [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  adcseq_top i_dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RC_CLK(rc_clk), .CMP_HIGH(cmp_high), .SMALL_PKG(small_pkg),
    .PAD_IN(pad_in), .PAD_DIGITAL_EN(pad_digital_en), .PAD_DIG_IN(pad_dig_in),
    .DAC_CODE(dac_code), .SAMPLE_CLOSED(sample_closed), .VREF_POS_EXT(vref_pos_ext),
    .VREF_NEG_EXT(vref_neg_ext), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // rc period deliberately unrelated to the system clock
  initial begin
    rc_clk = 1'b0;
    forever #126 rc_clk = ~rc_clk;
  end

  // ----------------------------------------
  // bus access and conversion tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rdat, {24'h000000, e})
  endtask

  // counts closed cycles before the switch opens, then open cycles until it closes
  task automatic conv(input logic [7:0] c1);
    apb(1'b1, OFS_CTL1, c1);
    if (c1[5:3] == 3'h0) repeat (4) @(posedge clk);
    apb(1'b1, OFS_CTL0, 8'h03);
    acq = 0;
    low = 0;
    for (int i = 0; i < 5000; i++) begin
      @(posedge clk);
      if (sample_closed !== 1'b1) low++;
      else if (low > 0) break;
      else acq++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    cmp_high = 1'b1;
    small_pkg = 1'b0;
    pad_in = 16'hFFFF;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_CTL0, RST_CTL0);
    rd(OFS_CTL1, RST_CTL1);
    rd(OFS_PCH, RST_PCH);
    rd(OFS_STAT, 8'h00);
    apb(1'b0, 12'h01C, 8'h00);
    `CHK({rerr, rdat}, 33'h100000000)
    apb(1'b1, OFS_PCH, 8'hA5);
    apb(1'b1, OFS_PCL, 8'hFF);
    repeat (5) @(posedge clk);
    `CHK(pad_digital_en, 16'hA5DF)
    `CHK(pad_dig_in, 16'hA5DF)
    rd(OFS_PCL, 8'hDF);
    small_pkg <= 1'b1;
    pad_in <= 16'h0F0F;
    repeat (5) @(posedge clk);
    `CHK(pad_digital_en, 16'h05DF)
    `CHK(pad_dig_in, 16'h050F)
    rd(OFS_PCH, 8'hA5);
    apb(1'b1, OFS_CTL0, 8'h41);
    repeat (2) @(posedge clk);
    `CHK({vref_neg_ext, vref_pos_ext}, 2'b01)
    apb(1'b1, OFS_CTL0, 8'h81);
    repeat (2) @(posedge clk);
    `CHK({vref_neg_ext, vref_pos_ext}, 2'b10)
    for (int s = 0; s < 8; s++) begin
      cmp_high <= s[1];
      apb(1'b1, OFS_STAT, 8'h02);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      conv({s[0], 1'b0, s[2:0], s[2:0]});
      nn = (divs[s] == 0) ? 5 : divs[s];
      `CHK(acq >= acqp[s] * nn - nn - 2 && acq <= acqp[s] * nn + nn + 4, 1'b1)
      `CHK(low >= 12 * nn - 4 && low <= 14 * nn + 6, 1'b1)
      `CHK(irq, 1'b1)
      rd(OFS_CTL0, 8'h01);
      rd(OFS_STAT, 8'h03);
      v = s[1] ? 10'h3FF : 10'h000;
      `CHK(dac_code, v)
      ex = s[0] ? {6'h00, v} : {v, 6'h00};
      rd(OFS_RESH, ex[15:8]);
      rd(OFS_RESL, ex[7:0]);
    end
    apb(1'b1, OFS_RESH, 8'h5A);
    apb(1'b1, OFS_RESL, 8'h3C);
    apb(1'b1, OFS_STAT, 8'h00);
    apb(1'b1, OFS_CTL1, 8'h86);
    apb(1'b1, OFS_CTL0, 8'h03);
    repeat (100) @(posedge clk);
    `CHK(sample_closed, 1'b0)
    rd(OFS_CTL0, 8'h03);
    apb(1'b1, OFS_CTL0, 8'h01);
    repeat (300) @(posedge clk);
    rd(OFS_RESH, 8'h5A);
    rd(OFS_RESL, 8'h3C);
    rd(OFS_STAT, 8'h00);
    `CHK(sample_closed, 1'b1)
    apb(1'b1, OFS_CTL0, 8'h03);
    repeat (200) @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({sample_closed, irq, pad_digital_en}, 18'h00000)
    arst_n <= 1'b1;
    rd(OFS_CTL0, RST_CTL0);
    rd(OFS_CTL1, RST_CTL1);
    rd(OFS_PCH, RST_PCH);
    rd(OFS_RESH, 8'h5A);
    test_done;
  end

  // whole sequence needs well under ten thousand cycles
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule
`undef CHK
`default_nettype wire

// *** verilog/adcseq_pkg.sv ***
// package: register map, reset values and timing tables of the conversion sequencer
`default_nettype none
package adcseq_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_CTL0 = 12'h000;
  localparam logic [11:0] OFS_CTL1 = 12'h004;
  localparam logic [11:0] OFS_PCL = 12'h008;
  localparam logic [11:0] OFS_PCH = 12'h00C;
  localparam logic [11:0] OFS_RESH = 12'h010;
  localparam logic [11:0] OFS_RESL = 12'h014;
  localparam logic [11:0] OFS_STAT = 12'h018;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int C0_EN = 0;
  localparam int C0_RUN = 1;
  localparam int C0_VPOS = 6;
  localparam int C0_VNEG = 7;
  localparam int C1_FMT = 7;
  localparam int ST_DONE = 0;
  localparam int ST_IRQEN = 1;
  localparam int PCL_GAP = 5;
  localparam logic [7:0] RST_CTL0 = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'h00;
  localparam logic [7:0] RST_PCL = 8'h00;
  localparam logic [7:0] RST_PCH = 8'h00;
  localparam logic [7:0] PCH_SMALL_MASK = 8'hF0;
  // ----------------------------------------
  // timing in conversion-clock periods
  // ----------------------------------------
  localparam logic [3:0] CONV_LAST = 4'hA;
  localparam logic [1:0] RECOVERY_TADS = 2'h2;
  localparam logic [9:0] SAR_FIRST = 10'h200;
  localparam logic [2:0] CLK_SEL_RC = 3'h3;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_ACQ = 4'h2,
    S_CONV = 4'h4,
    S_WAIT = 4'h8
  } adcseq_state_t;

  // acquisition delay per select code
  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0C;
      3'h6: acq_tads = 5'h10;
      3'h7: acq_tads = 5'h14;
      default: acq_tads = 5'h00;
    endcase
  endfunction

  // system clocks per conversion period, minus one
  function automatic logic [5:0] tad_div_m1(input logic [2:0] sel);
    case (sel)
      3'h0: tad_div_m1 = 6'h01;
      3'h1: tad_div_m1 = 6'h07;
      3'h2: tad_div_m1 = 6'h1F;
      3'h4: tad_div_m1 = 6'h03;
      3'h5: tad_div_m1 = 6'h0F;
      3'h6: tad_div_m1 = 6'h3F;
      default: tad_div_m1 = 6'h01;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** verilog/adcseq_top.sv ***
// module: conversion sequencer with APB registers and pin configuration
//
// Chosen here: the APB interface to the registers and the register offsets.
`default_nettype none
// What this block does
// R1 - select bit 1 digital, 0 analog reads zero
// R2 - small package: top four bits inert storage
// R3 - software selects supply or external references
// R4 - software picks RC clock before sleeping
// R5 - completion loads result, clears run, sets done
// R6 - reset restores registers, stops any conversion
// R7 - power-on reset leaves result pair untouched
// R8 - two conversion periods before next acquisition
// R9 - zero acquisition field: convert at once
// R10 - software times acquisition when field zero
// R11 - nonzero field: sample programmed periods first
// R12 - sampling resumes after every conversion
// R13 - run bit set through acquisition and conversion
// R14 - conversion start opens the sampling switch
// R15 - ten-bit successive approximation, one bit per step over ten steps
// R16 - software polls run bit or waits interrupt
// R17 - done flag cleared only by software or reset
// R18 - acquisition codes give 0,2,4,6,8,12,16,20
// R19 - clock select: divided clock or RC
// R20 - clearing run aborts, result kept
// R21 - conversion lasts eleven conversion periods
// R22 - interrupt only when done and enable set
// R23 - result justified by format bit
module adcseq_top
  import adcseq_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RC_CLK,
  input wire logic CMP_HIGH,
  input wire logic SMALL_PKG,
  input wire logic [15:0] PAD_IN,
  output logic [15:0] PAD_DIGITAL_EN,
  output logic [15:0] PAD_DIG_IN,
  output logic [9:0] DAC_CODE,
  output logic SAMPLE_CLOSED,
  output logic VREF_POS_EXT,
  output logic VREF_NEG_EXT,
  output logic IRQ
);
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] pcl;
    logic [7:0] pch;
    logic done;
    logic irqen;
    adcseq_state_t state;
    logic [4:0] acq_cnt;
    logic [3:0] bit_cnt;
    logic [1:0] rec_cnt;
    logic [9:0] sar;
    logic [5:0] div_cnt;
    logic bit_conversion_period;
    logic [2:0] rc_s;
    logic [1:0] cmp_s;
    logic [1:0] pkg_s;
    logic [15:0] pad_s0;
    logic [15:0] pad_s1;
    logic [15:0] dig_en;
    logic [15:0] dig_in;
    logic sw;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } adcseq_regs_t;

  adcseq_regs_t st_ff;
  adcseq_regs_t nxt_st;
  logic [7:0] res_hi_ff;
  logic [7:0] res_lo_ff;
  logic complete;
  logic wr_en;
  logic [7:0] w8;
  logic run_new;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    complete = 1'b0;
    run_new = 1'b0;
    w8 = PWDATA[7:0];
    nxt_st.rc_s = {st_ff.rc_s[1:0], RC_CLK};
    nxt_st.cmp_s = {st_ff.cmp_s[0], CMP_HIGH};
    nxt_st.pkg_s = {st_ff.pkg_s[0], SMALL_PKG};
    nxt_st.pad_s0 = PAD_IN;
    nxt_st.pad_s1 = st_ff.pad_s0;
    // conversion clock enable
    if (st_ff.ctl1[1:0] == CLK_SEL_RC[1:0]) begin // [R19]
      nxt_st.div_cnt = 6'h00;
      nxt_st.bit_conversion_period = st_ff.rc_s[1] & ~st_ff.rc_s[2];
    end else if (st_ff.div_cnt >= tad_div_m1(st_ff.ctl1[2:0])) begin // [R19]
      nxt_st.div_cnt = 6'h00;
      nxt_st.bit_conversion_period = 1'b1;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 6'h01;
      nxt_st.bit_conversion_period = 1'b0;
    end
    // apb: answer is prepared in setup, pready high for the access cycle
    wr_en = PSEL & PENABLE & st_ff.pready & PWRITE & ~st_ff.pslverr;
    nxt_st.pready = PSEL & ~PENABLE;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata = 32'h0000_0000;
    if (PSEL & ~PENABLE) begin
      case (PADDR)
        OFS_CTL0: nxt_st.prdata[7:0] = st_ff.ctl0; // [R13]
        OFS_CTL1: nxt_st.prdata[7:0] = st_ff.ctl1;
        OFS_PCL: nxt_st.prdata[7:0] = st_ff.pcl;
        OFS_PCH: nxt_st.prdata[7:0] = st_ff.pch; // [R2]
        OFS_RESH: nxt_st.prdata[7:0] = res_hi_ff;
        OFS_RESL: nxt_st.prdata[7:0] = res_lo_ff;
        OFS_STAT: nxt_st.prdata[1:0] = {st_ff.irqen, st_ff.done};
        default: nxt_st.pslverr = 1'b1;
      endcase
    end
    if (wr_en) begin
      case (PADDR)
        OFS_CTL0: begin
          // run only starts when the converter was already on
          run_new = w8[C0_RUN] & w8[C0_EN] & st_ff.ctl0[C0_EN];
          nxt_st.ctl0 = w8; // [R3]
          nxt_st.ctl0[C0_RUN] = run_new | (st_ff.ctl0[C0_RUN] & w8[C0_RUN] & w8[C0_EN]);
        end
        OFS_CTL1: nxt_st.ctl1 = w8;
        OFS_PCL: begin
          nxt_st.pcl = w8;
          nxt_st.pcl[PCL_GAP] = 1'b0;
        end
        OFS_PCH: nxt_st.pch = w8; // [R2]
        OFS_STAT: begin
          nxt_st.done = w8[ST_DONE]; // [R17]
          nxt_st.irqen = w8[ST_IRQEN];
        end
        default: ;
      endcase
    end
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    case (st_ff.state)
      S_IDLE: begin
        if (nxt_st.ctl0[C0_RUN]) begin
          if (st_ff.ctl1[5:3] == 3'h0) begin // [R9]
            nxt_st.state = S_CONV;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.sar = SAR_FIRST;
          end else begin // [R11]
            nxt_st.state = S_ACQ;
            nxt_st.acq_cnt = acq_tads(st_ff.ctl1[5:3]); // [R18]
          end
        end
      end
      S_ACQ: begin
        if (!nxt_st.ctl0[C0_RUN]) begin // [R20]
          nxt_st.state = S_WAIT;
          nxt_st.rec_cnt = RECOVERY_TADS;
        end else if (st_ff.bit_conversion_period) begin
          if (st_ff.acq_cnt == 5'h01) begin // [R11]
            nxt_st.state = S_CONV;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.sar = SAR_FIRST;
          end else begin
            nxt_st.acq_cnt = st_ff.acq_cnt - 5'h01;
          end
        end
      end
      S_CONV: begin
        if (!nxt_st.ctl0[C0_RUN]) begin // [R20]
          nxt_st.state = S_WAIT;
          nxt_st.rec_cnt = RECOVERY_TADS;
        end else if (st_ff.bit_conversion_period) begin
          // period 0 settles the first trial, periods 1..10 decide one bit each
          if (st_ff.bit_cnt != 4'h0) begin // [R15]
            nxt_st.sar[4'(CONV_LAST - st_ff.bit_cnt)] = st_ff.cmp_s[1];
            if (st_ff.bit_cnt != CONV_LAST) begin
              nxt_st.sar[4'(CONV_LAST - st_ff.bit_cnt - 4'h1)] = 1'b1;
            end
          end
          nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          if (st_ff.bit_cnt == CONV_LAST) begin // [R21]
            complete = 1'b1;
            nxt_st.ctl0[C0_RUN] = 1'b0; // [R5]
            nxt_st.done = 1'b1; // [R5]
            nxt_st.state = S_WAIT;
            nxt_st.rec_cnt = RECOVERY_TADS;
          end
        end
      end
      S_WAIT: begin
        if (st_ff.bit_conversion_period) begin // [R8]
          nxt_st.rec_cnt = st_ff.rec_cnt - 2'h1;
          if (st_ff.rec_cnt == 2'h1) begin
            nxt_st.state = S_IDLE;
          end
        end
      end
      default: nxt_st.state = S_IDLE;
    endcase
    if (!nxt_st.ctl0[C0_EN]) begin
      nxt_st.state = S_IDLE;
      nxt_st.ctl0[C0_RUN] = 1'b0;
    end
    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    nxt_st.sw = nxt_st.ctl0[C0_EN] & (nxt_st.state == S_IDLE || nxt_st.state == S_ACQ); // [R14] [R12]
    nxt_st.irq = nxt_st.done & nxt_st.irqen; // [R22]
    nxt_st.dig_en = {st_ff.pch & ~({8{st_ff.pkg_s[1]}} & PCH_SMALL_MASK), st_ff.pcl}; // [R2]
    nxt_st.dig_in = st_ff.pad_s1 & st_ff.dig_en; // [R1]
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin // [R6]
      st_ff <= '{ctl0: RST_CTL0, ctl1: RST_CTL1, pcl: RST_PCL, pch: RST_PCH,
                 state: S_IDLE, sar: 10'h000, prdata: 32'h0000_0000,
                 dig_en: 16'h0000, dig_in: 16'h0000, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // result pair has no reset so power-on leaves its contents as they were
  always_ff @(posedge CLK) begin
    if (complete) begin // [R7] [R23]
      if (st_ff.ctl1[C1_FMT]) begin
        res_hi_ff <= {6'h00, nxt_st.sar[9:8]};
        res_lo_ff <= nxt_st.sar[7:0];
      end else begin
        res_hi_ff <= nxt_st.sar[9:2];
        res_lo_ff <= {nxt_st.sar[1:0], 6'h00};
      end
    end else if (wr_en && PADDR == OFS_RESH) begin
      res_hi_ff <= w8;
    end else if (wr_en && PADDR == OFS_RESL) begin
      res_lo_ff <= w8;
    end
  end

  assign PRDATA = st_ff.prdata;
  assign PREADY = st_ff.pready;
  assign PSLVERR = st_ff.pslverr;
  assign PAD_DIGITAL_EN = st_ff.dig_en;
  assign PAD_DIG_IN = st_ff.dig_in;
  assign DAC_CODE = st_ff.sar;
  assign SAMPLE_CLOSED = st_ff.sw;
  assign VREF_POS_EXT = st_ff.ctl0[C0_VPOS];
  assign VREF_NEG_EXT = st_ff.ctl0[C0_VNEG];
  assign IRQ = st_ff.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_done_on_finish: assert property ( // [R5]
    st_ff.state == S_CONV && st_ff.bit_conversion_period && st_ff.bit_cnt == CONV_LAST && st_ff.ctl0[C0_RUN]
    && st_ff.ctl0[C0_EN] && !wr_en |=> st_ff.done && !st_ff.ctl0[C0_RUN] && st_ff.state == S_WAIT)
    else $error("completion did not set done and clear run");
  a_zero_acq_start: assert property ( // [R9]
    st_ff.state == S_IDLE && nxt_st.ctl0[C0_RUN] && st_ff.ctl1[5:3] == 3'h0
    |=> st_ff.state == S_CONV && st_ff.bit_cnt == 4'h0)
    else $error("zero acquisition did not convert at once");
  a_acq_then_conv: assert property ( // [R11]
    st_ff.state == S_ACQ && st_ff.bit_conversion_period && st_ff.acq_cnt == 5'h01 && nxt_st.ctl0[C0_RUN]
    |=> st_ff.state == S_CONV)
    else $error("acquisition end did not start conversion");
  a_recovery_hold: assert property ( // [R8]
    $rose(st_ff.state == S_WAIT) |-> st_ff.rec_cnt == RECOVERY_TADS ##1 st_ff.state == S_WAIT)
    else $error("recovery wait too short");
  a_switch_open: assert property ( // [R14]
    st_ff.state == S_CONV |-> !SAMPLE_CLOSED)
    else $error("sampling switch closed during conversion");
  a_irq_gate: assert property ( // [R22]
    IRQ |-> st_ff.done && st_ff.irqen)
    else $error("interrupt without done and enable");
  a_abort_keeps: assert property ( // [R20]
    st_ff.state == S_CONV && !nxt_st.ctl0[C0_RUN] && !complete
    |=> $stable(res_hi_ff) && $stable(res_lo_ff))
    else $error("abort changed the result");
  a_pin_analog_zero: assert property ( // [R1]
    (PAD_DIG_IN & ~$past(PAD_DIGITAL_EN)) == 16'h0000)
    else $error("analog pin read not zero");
  a_small_pkg_inert: assert property ( // [R2]
    st_ff.pkg_s[1] |=> PAD_DIGITAL_EN[15:12] == 4'h0)
    else $error("upper selects act on small package");
  a_conv_length: assert property ( // [R21]
    st_ff.state == S_CONV |-> st_ff.bit_cnt <= CONV_LAST)
    else $error("conversion ran past eleven periods");

  c_full_conv: cover property (st_ff.state == S_CONV ##1 st_ff.done && st_ff.state == S_WAIT);
  c_acq_path: cover property (st_ff.state == S_ACQ ##1 st_ff.state == S_CONV);
  c_abort: cover property (st_ff.state == S_CONV ##1 st_ff.state == S_WAIT && !st_ff.done);
endmodule
`default_nettype wire
